// ---- hdl/adcd_pkg.sv ----
/*
  Shared constants and types for the converter output formatter.
  Assumes a 25 MHz system clock and an APB master with 32-bit data.
*/
package adcd_pkg;

  // ************************************************************
  // Widths and latencies
  // ************************************************************
  localparam int unsigned ADCD_DW = 8;
  localparam int unsigned ADCD_FS_W = 9;
  localparam int unsigned ADCD_REG_W = 16;
  localparam int unsigned ADCD_LAT_NEW = 13;
  localparam int unsigned ADCD_LAT_OLD = 14;
  localparam int unsigned ADCD_AW = 8;
  // Counts are taken one cycle after the fall that writes the line
  localparam logic [3:0] ADCD_VALID_NEW = 4'(ADCD_LAT_NEW + 1);
  localparam logic [3:0] ADCD_VALID_OLD = 4'(ADCD_LAT_OLD + 1);
  localparam logic [3:0] ADCD_CNT_MAX = ADCD_VALID_OLD;
  localparam logic [1:0] ADCD_CAP_WAIT = 2'h2;
  localparam logic [3:0] ADCD_TRIM_MID = 4'h8;
  localparam logic [3:0] ADCD_TRIM_MAX = 4'hF;
  localparam logic [3:0] ADCD_TRIM_MIN = 4'h0;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [5:0] ADCD_IDX_STATUS = 6'h00;
  localparam logic [5:0] ADCD_IDX_EXT_CFG = 6'h01;
  localparam logic [5:0] ADCD_IDX_FULL_SCALE = 6'h02;
  localparam logic [5:0] ADCD_IDX_DES_SRC = 6'h0E;
  localparam int unsigned ADCD_CFG_DES_BIT = 6;
  localparam int unsigned ADCD_CFG_DCR_BIT = 7;
  localparam int unsigned ADCD_CFG_EDGE_BIT = 8;
  localparam int unsigned ADCD_CFG_SINGLE_BIT = 10;
  localparam int unsigned ADCD_DESSRC_Q_BIT = 15;
  localparam logic [15:0] ADCD_EXT_RST = 16'h0480;
  localparam logic [8:0] ADCD_FS_RST = 9'h100;
  localparam logic [1:0] ADCD_ALIGN = 2'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    ADCD_PIN_LOW = 2'b00,
    ADCD_PIN_HIGH = 2'b01,
    ADCD_PIN_MID = 2'b10
  } adcd_pin_t;

  typedef struct packed {
    logic [ADCD_DW-1:0] rise;
    logic [ADCD_DW-1:0] fall_i;
    logic [ADCD_DW-1:0] fall_q;
  } adcd_slot_t;

  typedef struct packed {
    logic [ADCD_DW-1:0] q_older;
    logic [ADCD_DW-1:0] i_older;
    logic [ADCD_DW-1:0] q_newer;
    logic [ADCD_DW-1:0] i_newer;
  } adcd_bus_t;

  typedef struct packed {
    logic ext;
    logic des;
    logic des_q;
    logic ddr;
    logic edge_rise;
    logic dcr_en;
  } adcd_mode_t;

  typedef struct packed {
    logic [15:0] zero;
    logic [3:0] trim;
    logic v_old;
    logic v_new;
    logic ext;
    logic des;
    logic ddr;
    logic edge_rise;
    adcd_pin_t des_code;
    adcd_pin_t edge_code;
    adcd_pin_t fs_code;
  } adcd_status_t;

endpackage

// ---- hdl/adcd_delay_line.sv ----
/*
  Sample delay line: one slot written per input clock fall, two taps.
  Assumes the write strobe is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module adcd_delay_line #(
  parameter int unsigned W = 24,
  parameter int unsigned TAP_NEW = 13,
  parameter int unsigned TAP_OLD = 14
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write side
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  // Registered taps
  output logic [W-1:0] tap_new,
  output logic [W-1:0] tap_old
);

  typedef struct packed {
    logic [TAP_OLD-1:0][W-1:0] line;
    logic [W-1:0] t_new;
    logic [W-1:0] t_old;
  } adcd_dl_st_t;

  adcd_dl_st_t st_q;
  adcd_dl_st_t st_d;

  // ************************************************************
  // Shift and tap
  // ************************************************************
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      // Taps read before the shift: entry k holds the sample k+1 falls old
      st_d.t_new = st_q.line[TAP_NEW-1];
      st_d.t_old = st_q.line[TAP_OLD-1];
      for (int k = TAP_OLD - 1; k > 0; k--) begin
        st_d.line[k] = st_q.line[k-1];
      end
      st_d.line[0] = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tap_new = st_q.t_new;
  assign tap_old = st_q.t_old;

endmodule

`default_nettype wire

// ---- hdl/adcd_top.sv ----
/*
  Output formatter and demultiplexer of a dual-channel 8-bit converter.
  Assumes the sample clock and sample words arrive asynchronously and
  are slow enough for the 25 MHz system clock to see every edge.
*/
// Added by the designer: the register addresses and the APB register port.
// Overview of operation
// RULE_01: Full-scale pin at mid-level selects the 9-bit register code.
// RULE_02: Edge pin high: forwarded clock at half rate, data on its rise.
// RULE_03: Edge pin low: forwarded clock at half rate, data on its fall.
// RULE_04: Edge pin mid: quarter-rate forwarded clock, data on both edges.
// RULE_05: Forwarded clock driven differentially; receiver latches words with it.
// RULE_06: Duty-cycle regulator on after reset; switched only through register 1.
// RULE_07: Interleave mode samples the chosen input on both clock edges.
// RULE_08: Interleaved samples spread four wide across the output buses.
// RULE_09: Group order oldest to newest: Q older, I older, Q newer, I newer.
// RULE_10: Interleave under pin control samples the first input only.
// RULE_11: Under register control register 14 picks the interleaved input.
// RULE_12: Interleave mode trims I/Q clock phase continuously in background.
// RULE_13: Controller calibrates before interleave and after large temperature shifts. This code has no calibration logic.
// RULE_14: I newer carries fall sample 13 cycles back, I older 14.
// RULE_15: Normal mode Q newer and Q older carry falls 13 and 14 back.
// RULE_16: Interleave Q newer carries rise sample 13.5 cycles back.
// RULE_17: Interleave Q older carries rise sample 14.5 cycles back.
// RULE_18: Output words are offset binary.
// RULE_19: Newer words valid after 13 input clocks, older after 14.
// RULE_20: Three-level pins decode to two-bit codes, latched once after reset.
// RULE_21: All four output buses are registered on one common edge.
`timescale 1ns/1ps
`default_nettype none

module adcd_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // APB register port
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [adcd_pkg::ADCD_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Three-level pins as comparator pairs
  input wire logic FULL_SCALE_SELECT_ABOVE,
  input wire logic FULL_SCALE_SELECT_BELOW,
  input wire logic OUTPUT_EDGE_SELECT_ABOVE,
  input wire logic OUTPUT_EDGE_SELECT_BELOW,
  input wire logic DUAL_EDGE_SELECT_ABOVE,
  input wire logic DUAL_EDGE_SELECT_BELOW,
  // Sample clock and raw two's complement words
  input wire logic SAMPLE_CLOCK_IN,
  input wire logic [adcd_pkg::ADCD_DW-1:0] ANALOG_IN_FIRST,
  input wire logic [adcd_pkg::ADCD_DW-1:0] ANALOG_IN_SECOND,
  // Forwarded clock and output buses
  output logic FORWARDED_DATA_CLOCK_P,
  output logic FORWARDED_DATA_CLOCK_N,
  output logic [adcd_pkg::ADCD_DW-1:0] I_WORD_NEWER,
  output logic [adcd_pkg::ADCD_DW-1:0] I_WORD_OLDER,
  output logic [adcd_pkg::ADCD_DW-1:0] Q_WORD_NEWER,
  output logic [adcd_pkg::ADCD_DW-1:0] Q_WORD_OLDER,
  output logic WORD_NEWER_VALID,
  output logic WORD_OLDER_VALID,
  // Analog front-end controls
  output logic [adcd_pkg::ADCD_FS_W-1:0] FULL_SCALE_CODE,
  output logic FULL_SCALE_FROM_CODE,
  output logic FULL_SCALE_PIN_HIGH,
  output logic DUTY_CYCLE_REG_EN,
  output logic [3:0] PHASE_TRIM
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [2:0] clk_s;
    logic [adcd_pkg::ADCD_DW-1:0] ai_s1;
    logic [adcd_pkg::ADCD_DW-1:0] ai_s2;
    logic [adcd_pkg::ADCD_DW-1:0] aq_s1;
    logic [adcd_pkg::ADCD_DW-1:0] aq_s2;
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic [1:0] cap_cnt;
    logic capped;
    adcd_pkg::adcd_pin_t fs_code;
    adcd_pkg::adcd_pin_t edge_code;
    adcd_pkg::adcd_pin_t des_code;
    logic [adcd_pkg::ADCD_REG_W-1:0] ext_cfg;
    logic [adcd_pkg::ADCD_FS_W-1:0] fs_reg;
    logic des_src_q;
    logic [adcd_pkg::ADCD_DW-1:0] rise_hold;
    logic phase;
    logic [3:0] fall_cnt;
    logic upd;
    logic nupd;
    logic forwarded_data_clock;
    adcd_pkg::adcd_bus_t bus;
    logic v_new;
    logic v_old;
    logic [3:0] trim;
    logic [31:0] prdata;
  } adcd_st_t;

  localparam adcd_st_t ST_RST = '{
    fs_code: adcd_pkg::ADCD_PIN_LOW,
    edge_code: adcd_pkg::ADCD_PIN_LOW,
    des_code: adcd_pkg::ADCD_PIN_LOW,
    ext_cfg: adcd_pkg::ADCD_EXT_RST,
    fs_reg: adcd_pkg::ADCD_FS_RST,
    trim: adcd_pkg::ADCD_TRIM_MID,
    default: '0
  };

  adcd_st_t st_q;
  adcd_st_t st_d;
  adcd_pkg::adcd_mode_t mode;
  adcd_pkg::adcd_slot_t slot_wr;
  adcd_pkg::adcd_slot_t tap_new;
  adcd_pkg::adcd_slot_t tap_old;
  adcd_pkg::adcd_status_t status;
  logic rise_evt;
  logic fall_evt;
  logic [adcd_pkg::ADCD_DW-1:0] ai;
  logic [adcd_pkg::ADCD_DW-1:0] aq;
  logic [adcd_pkg::ADCD_DW-1:0] sel;
  logic [5:0] idx;
  logic mapped;
  logic acc;

  function automatic adcd_pkg::adcd_pin_t dec3(input logic above, input logic below);
    if (above) begin
      return adcd_pkg::ADCD_PIN_HIGH;
    end else if (below) begin
      return adcd_pkg::ADCD_PIN_LOW;
    end
    return adcd_pkg::ADCD_PIN_MID;
  endfunction

  // ************************************************************
  // Mode decode
  // ************************************************************
  always_comb begin
    mode.ext = (st_q.fs_code == adcd_pkg::ADCD_PIN_MID);
    if (mode.ext) begin
      mode.ddr = !st_q.ext_cfg[adcd_pkg::ADCD_CFG_SINGLE_BIT];
      mode.edge_rise = st_q.ext_cfg[adcd_pkg::ADCD_CFG_EDGE_BIT];
      mode.des = st_q.ext_cfg[adcd_pkg::ADCD_CFG_DES_BIT];
      mode.des_q = st_q.des_src_q; // see RULE_11
      mode.dcr_en = st_q.ext_cfg[adcd_pkg::ADCD_CFG_DCR_BIT]; // see RULE_06
    end else begin
      mode.ddr = (st_q.edge_code == adcd_pkg::ADCD_PIN_MID); // see RULE_04
      mode.edge_rise = (st_q.edge_code == adcd_pkg::ADCD_PIN_HIGH);
      mode.des = (st_q.des_code == adcd_pkg::ADCD_PIN_MID);
      mode.des_q = 1'b0; // see RULE_10
      mode.dcr_en = 1'b1;
    end
  end

  // Edges of the synchronised sample clock; stage 0 feeds stage 1 only
  assign rise_evt = st_q.clk_s[1] && !st_q.clk_s[2];
  assign fall_evt = !st_q.clk_s[1] && st_q.clk_s[2];
  // Two's complement in, offset binary out
  assign ai = {~st_q.ai_s2[adcd_pkg::ADCD_DW-1], st_q.ai_s2[adcd_pkg::ADCD_DW-2:0]}; // see RULE_18
  assign aq = {~st_q.aq_s2[adcd_pkg::ADCD_DW-1], st_q.aq_s2[adcd_pkg::ADCD_DW-2:0]}; // see RULE_18
  assign sel = mode.des_q ? aq : ai;
  // Interleave: I buses take falls of the chosen input, Q buses its rises
  assign slot_wr = '{rise: st_q.rise_hold, fall_i: (mode.des ? sel : ai), fall_q: aq}; // see RULE_07

  assign idx = PADDR[adcd_pkg::ADCD_AW-1:2];
  assign acc = PSEL && PENABLE;
  assign mapped = (PADDR[1:0] == adcd_pkg::ADCD_ALIGN) &&
                  (idx == adcd_pkg::ADCD_IDX_STATUS || idx == adcd_pkg::ADCD_IDX_EXT_CFG ||
                   idx == adcd_pkg::ADCD_IDX_FULL_SCALE || idx == adcd_pkg::ADCD_IDX_DES_SRC);

  always_comb begin
    status = '0;
    status.trim = st_q.trim;
    status.v_old = st_q.v_old;
    status.v_new = st_q.v_new;
    status.ext = mode.ext;
    status.des = mode.des;
    status.ddr = mode.ddr;
    status.edge_rise = mode.edge_rise;
    status.des_code = st_q.des_code;
    status.edge_code = st_q.edge_code;
    status.fs_code = st_q.fs_code;
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_d = st_q;
    st_d.clk_s = {st_q.clk_s[1:0], SAMPLE_CLOCK_IN};
    st_d.ai_s1 = ANALOG_IN_FIRST;
    st_d.ai_s2 = st_q.ai_s1;
    st_d.aq_s1 = ANALOG_IN_SECOND;
    st_d.aq_s2 = st_q.aq_s1;
    st_d.pin_s1 = {FULL_SCALE_SELECT_ABOVE, FULL_SCALE_SELECT_BELOW,
                   OUTPUT_EDGE_SELECT_ABOVE, OUTPUT_EDGE_SELECT_BELOW,
                   DUAL_EDGE_SELECT_ABOVE, DUAL_EDGE_SELECT_BELOW};
    st_d.pin_s2 = st_q.pin_s1;
    st_d.upd = fall_evt && st_q.phase;
    st_d.nupd = fall_evt && !st_q.phase;

    // Pins are caught once; the control mode may not change while running
    if (!st_q.capped) begin
      st_d.cap_cnt = 2'(st_q.cap_cnt + 2'h1);
      if (st_q.cap_cnt == adcd_pkg::ADCD_CAP_WAIT) begin
        st_d.capped = 1'b1;
        st_d.fs_code = dec3(st_q.pin_s2[5], st_q.pin_s2[4]); // see RULE_20
        st_d.edge_code = dec3(st_q.pin_s2[3], st_q.pin_s2[2]); // see RULE_20
        st_d.des_code = dec3(st_q.pin_s2[1], st_q.pin_s2[0]); // see RULE_20
      end
    end

    if (rise_evt) begin
      st_d.rise_hold = sel; // see RULE_07
    end

    if (fall_evt) begin
      st_d.phase = !st_q.phase;
      if (st_q.fall_cnt != adcd_pkg::ADCD_CNT_MAX) begin
        st_d.fall_cnt = 4'(st_q.fall_cnt + 4'h1);
      end
      // Crude background phase servo: compare the two edge samples
      if (mode.des) begin
        if (st_q.rise_hold > sel && st_q.trim != adcd_pkg::ADCD_TRIM_MAX) begin
          st_d.trim = 4'(st_q.trim + 4'h1); // see RULE_12
        end else if (st_q.rise_hold <= sel && st_q.trim != adcd_pkg::ADCD_TRIM_MIN) begin
          st_d.trim = 4'(st_q.trim - 4'h1); // see RULE_12
        end
      end
    end

    // One cycle after the fall the taps are stable; every second fall updates
    if (st_q.upd) begin
      st_d.bus.i_newer = tap_new.fall_i; // see RULE_14
      st_d.bus.i_older = tap_old.fall_i; // see RULE_14
      st_d.bus.q_newer = mode.des ? tap_new.rise : tap_new.fall_q; // see RULE_15 RULE_16
      st_d.bus.q_older = mode.des ? tap_old.rise : tap_old.fall_q; // see RULE_15 RULE_17
      st_d.v_new = (st_q.fall_cnt >= adcd_pkg::ADCD_VALID_NEW); // see RULE_19
      st_d.v_old = (st_q.fall_cnt >= adcd_pkg::ADCD_VALID_OLD); // see RULE_19
      if (mode.ddr) begin
        st_d.forwarded_data_clock = !st_q.forwarded_data_clock; // see RULE_04
      end else begin
        st_d.forwarded_data_clock = mode.edge_rise; // see RULE_02 RULE_03
      end
    end else if (st_q.nupd && !mode.ddr) begin
      st_d.forwarded_data_clock = !mode.edge_rise; // see RULE_02 RULE_03
    end

    // Register port: read data fetched in setup, writes land in access
    if (PSEL && !PENABLE && !PWRITE) begin
      unique case (idx)
        adcd_pkg::ADCD_IDX_STATUS: st_d.prdata = status;
        adcd_pkg::ADCD_IDX_EXT_CFG: st_d.prdata = 32'(st_q.ext_cfg);
        adcd_pkg::ADCD_IDX_FULL_SCALE: st_d.prdata = 32'(st_q.fs_reg);
        adcd_pkg::ADCD_IDX_DES_SRC: begin
          st_d.prdata = '0;
          st_d.prdata[adcd_pkg::ADCD_DESSRC_Q_BIT] = st_q.des_src_q;
        end
        default: st_d.prdata = '0;
      endcase
    end
    if (acc && PWRITE && mapped) begin
      unique case (idx)
        adcd_pkg::ADCD_IDX_EXT_CFG: st_d.ext_cfg = PWDATA[adcd_pkg::ADCD_REG_W-1:0]; // see RULE_06
        adcd_pkg::ADCD_IDX_FULL_SCALE: st_d.fs_reg = PWDATA[adcd_pkg::ADCD_FS_W-1:0]; // see RULE_01
        adcd_pkg::ADCD_IDX_DES_SRC: st_d.des_src_q = PWDATA[adcd_pkg::ADCD_DESSRC_Q_BIT]; // see RULE_11
        default: st_d.prdata = st_q.prdata;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // Sample pipeline
  // ************************************************************
  adcd_delay_line #(
    .W($bits(adcd_pkg::adcd_slot_t)),
    .TAP_NEW(adcd_pkg::ADCD_LAT_NEW),
    .TAP_OLD(adcd_pkg::ADCD_LAT_OLD)
  ) u_adcd_delay_line (
    .clk(CLK),
    .rst_n(RESET_N),
    .wr_en(fall_evt),
    .wr_data(slot_wr),
    .tap_new(tap_new),
    .tap_old(tap_old)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  assign PRDATA = st_q.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !mapped;
  assign FORWARDED_DATA_CLOCK_P = st_q.forwarded_data_clock; // see RULE_05
  assign FORWARDED_DATA_CLOCK_N = !st_q.forwarded_data_clock; // see RULE_05
  // Bus order oldest to newest: Q older, I older, Q newer, I newer
  assign I_WORD_NEWER = st_q.bus.i_newer; // see RULE_08 RULE_09 RULE_21
  assign I_WORD_OLDER = st_q.bus.i_older;
  assign Q_WORD_NEWER = st_q.bus.q_newer;
  assign Q_WORD_OLDER = st_q.bus.q_older;
  assign WORD_NEWER_VALID = st_q.v_new;
  assign WORD_OLDER_VALID = st_q.v_old;
  assign FULL_SCALE_CODE = st_q.fs_reg;
  assign FULL_SCALE_FROM_CODE = mode.ext; // see RULE_01
  assign FULL_SCALE_PIN_HIGH = (st_q.fs_code == adcd_pkg::ADCD_PIN_HIGH);
  assign DUTY_CYCLE_REG_EN = mode.dcr_en;
  assign PHASE_TRIM = st_q.trim;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_upd_sdr;
    st_q.upd && !mode.ddr;
  endsequence

  property p_fs_source;
    (st_q.capped && st_q.fs_code == adcd_pkg::ADCD_PIN_MID) |-> FULL_SCALE_FROM_CODE;
  endproperty
  a_fs_source: assert property (p_fs_source) else $error("full scale not from code"); // see RULE_01

  property p_sdr_rise;
    s_upd_sdr ##0 mode.edge_rise |=> $rose(FORWARDED_DATA_CLOCK_P);
  endproperty
  a_sdr_rise: assert property (p_sdr_rise) else $error("data not on clock rise"); // see RULE_02

  property p_sdr_fall;
    s_upd_sdr ##0 !mode.edge_rise |=> $fell(FORWARDED_DATA_CLOCK_P);
  endproperty
  a_sdr_fall: assert property (p_sdr_fall) else $error("data not on clock fall"); // see RULE_03

  property p_ddr_toggle;
    (mode.ddr && !st_q.upd) |=> $stable(FORWARDED_DATA_CLOCK_P);
  endproperty
  a_ddr_toggle: assert property (p_ddr_toggle) else $error("ddr clock moved off update"); // see RULE_04

  property p_diff_clock;
    FORWARDED_DATA_CLOCK_P != FORWARDED_DATA_CLOCK_N;
  endproperty
  a_diff_clock: assert property (p_diff_clock) else $error("clock pair not complementary"); // see RULE_05

  property p_dcr_reset;
    $rose(RESET_N) |-> DUTY_CYCLE_REG_EN;
  endproperty
  a_dcr_reset: assert property (p_dcr_reset) else $error("regulator off after reset"); // see RULE_06

  property p_pin_des_first;
    (mode.des && !mode.ext) |-> !mode.des_q;
  endproperty
  a_pin_des_first: assert property (p_pin_des_first) else $error("second input under pins"); // see RULE_10

  property p_group_together;
    !st_q.upd |=> $stable(st_q.bus);
  endproperty
  a_group_together: assert property (p_group_together) else $error("buses moved apart"); // see RULE_21

  property p_trim_moves;
    (fall_evt && mode.des && st_q.trim != adcd_pkg::ADCD_TRIM_MAX &&
     st_q.trim != adcd_pkg::ADCD_TRIM_MIN) |=> $changed(PHASE_TRIM);
  endproperty
  a_trim_moves: assert property (p_trim_moves) else $error("phase trim idle"); // see RULE_12

  property p_valid_order;
    WORD_OLDER_VALID |-> WORD_NEWER_VALID;
  endproperty
  a_valid_order: assert property (p_valid_order) else $error("older valid before newer"); // see RULE_19

  property p_code_hold;
    st_q.capped |=> $stable({st_q.fs_code, st_q.edge_code, st_q.des_code});
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("pin code changed"); // see RULE_20

endmodule

`default_nettype wire

// ---- bench/adcd_rx_model.sv ----
/*
  Capture model of the receiving logic: latches the four buses on
  forwarded clock edges. Assumes the bench clock oversamples them.
*/
`timescale 1ns/1ps
`default_nettype none
module adcd_rx_model (
  // Clock
  input wire logic clk,
  // Forwarded clock and buses
  input wire logic fwd_p,
  input wire logic fwd_n,
  input wire adcd_pkg::adcd_bus_t bus,
  // Captured group
  output logic edge_seen,
  output logic got,
  output adcd_pkg::adcd_bus_t grp,
  output logic pair_ok
);
  logic p_q = 1'b0;
  adcd_pkg::adcd_bus_t last_q = '0;
  // Take a group only where clock and data moved on one edge
  always @(posedge clk) begin
    edge_seen <= fwd_p !== p_q;
    got <= (fwd_p !== p_q) && (bus !== last_q);
    grp <= bus;
    pair_ok <= fwd_n === ~fwd_p;
    last_q <= bus;
    p_q <= fwd_p;
  end
endmodule
`default_nettype wire

// ---- bench/test_adc_output_demux_timing.sv ----
/*
  Bench for the output formatter: pins, APB, a sample clock and a
  queue model of every sample. Assumes the design files come first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_adc_output_demux_timing;
  logic CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic SAMPLE_CLOCK_IN = 0, PREADY, PSLVERR, FP, FN, NV, OV;
  logic FS_FROM, FS_HIGH, DCR, edge_seen, got, pair_ok;
  logic [7:0] PADDR = '0, ANALOG_IN_FIRST = '0, ANALOG_IN_SECOND = '0;
  logic [7:0] IN, IO, QN, QO;
  logic [31:0] PWDATA = '0, PRDATA, rv;
  logic [1:0] fs_c = 2'h1, ed_c = 2'h1, ds_c = 2'h0;
  logic [8:0] FS_CODE, fsv;
  logic [3:0] TRIM;
  logic ev;
  adcd_pkg::adcd_bus_t grp;
  int fi[1024], fq[1024], ri[1024], rq[1024];
  int nf = 0, r0 = 0, tog = 0, cycles = 0, error_cnt = 0, compares = 0;
  bit ddr, rise, des, chq, moved;

  // ************************************************************
  // Design and capture model
  // ************************************************************
  adcd_top u_adcd_top (.CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .FULL_SCALE_SELECT_ABOVE(fs_c == 2'h1), .FULL_SCALE_SELECT_BELOW(fs_c == 2'h0),
    .OUTPUT_EDGE_SELECT_ABOVE(ed_c == 2'h1), .OUTPUT_EDGE_SELECT_BELOW(ed_c == 2'h0),
    .DUAL_EDGE_SELECT_ABOVE(ds_c == 2'h1), .DUAL_EDGE_SELECT_BELOW(ds_c == 2'h0),
    .SAMPLE_CLOCK_IN, .ANALOG_IN_FIRST, .ANALOG_IN_SECOND,
    .FORWARDED_DATA_CLOCK_P(FP), .FORWARDED_DATA_CLOCK_N(FN),
    .I_WORD_NEWER(IN), .I_WORD_OLDER(IO), .Q_WORD_NEWER(QN), .Q_WORD_OLDER(QO),
    .WORD_NEWER_VALID(NV), .WORD_OLDER_VALID(OV), .FULL_SCALE_CODE(FS_CODE),
    .FULL_SCALE_FROM_CODE(FS_FROM), .FULL_SCALE_PIN_HIGH(FS_HIGH),
    .DUTY_CYCLE_REG_EN(DCR), .PHASE_TRIM(TRIM));
  adcd_rx_model u_adcd_rx_model (.clk(CLK), .fwd_p(FP), .fwd_n(FN),
    .bus({QO, IO, QN, IN}), .edge_seen, .got, .grp, .pair_ok);

  // ************************************************************
  // Clocks and sample source
  // ************************************************************
  initial forever #20 CLK = ~CLK;
  // Words change 20 ns ahead of each edge, clear of the sync window
  initial begin
    #7;
    forever begin
      #140 ANALOG_IN_FIRST <= 8'($urandom);
      ANALOG_IN_SECOND <= 8'($urandom);
      #20 SAMPLE_CLOCK_IN <= 1'b1;
      ri[(nf + 1) % 1024] = ANALOG_IN_FIRST;
      rq[(nf + 1) % 1024] = ANALOG_IN_SECOND;
      #140 ANALOG_IN_FIRST <= 8'($urandom);
      ANALOG_IN_SECOND <= 8'($urandom);
      #20 SAMPLE_CLOCK_IN <= 1'b0;
      nf++;
      fi[nf % 1024] = ANALOG_IN_FIRST;
      fq[nf % 1024] = ANALOG_IN_SECOND;
    end
  end

  // ************************************************************
  // Model and checks
  // ************************************************************
  task automatic chk(string w, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", w, e, s);
    end
  endtask

  function automatic logic [31:0] expect_grp(int n);
    int c = n % 1024, d = (n + 1023) % 1024;
    logic [7:0] xc, xd, yc, yd;
    xc = 8'(chq ? fq[c] : fi[c]);
    xd = 8'(chq ? fq[d] : fi[d]);
    yc = 8'(des ? (chq ? rq[c] : ri[c]) : fq[c]);
    yd = 8'(des ? (chq ? rq[d] : ri[d]) : fq[d]);
    return {yd, xd, yc, xc} ^ 32'h8080_8080;
  endfunction

  always @(posedge CLK) begin
    cycles++;
    if (TRIM !== 4'h8) moved = 1;
    if (edge_seen === 1'b1) tog++;
    // Groups seen while reset is low are not results
    if (got === 1'b1 && RESET_N === 1'b1) begin
      chk("pair", 1, pair_ok);
      if (!ddr) chk("edge", rise, FP);
      if (nf - r0 >= 16) chk("valid", 2'h3, {OV, NV});
      if (NV === 1'b1) chk("early", 1, nf - r0 >= 14);
      if (OV === 1'b1) chk("early old", 1, nf - r0 >= 15);
      if (nf - r0 >= 18) chk("group", expect_grp(nf - 13), grp);
    end
    if (cycles == 6000) begin
      error_cnt++;
      summarize;
    end
  end

  task automatic apb(bit wr, logic [7:0] a, logic [31:0] d, output logic [31:0] r,
      output logic e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, logic er);
    apb(0, a, 0, rv, ev);
    chk("rdata", e, rv);
    chk("slverr", er, ev);
  endtask

  task automatic start(logic [1:0] f, g, h, bit m_ddr, m_rise, m_des, m_q);
    @(posedge CLK);
    RESET_N <= 1'b0;
    fs_c <= f;
    ed_c <= g;
    ds_c <= h;
    {ddr, rise, des, chq, moved} = {m_ddr, m_rise, m_des, m_q, 1'b0};
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    r0 = nf;
  endtask

  task automatic soak(string name);
    int t0 = nf;
    tog = 0;
    repeat (320) @(posedge CLK);
    t0 = tog - (ddr ? (nf - t0) / 2 : nf - t0);
    chk("rate", 1, t0 >= -2 && t0 <= 2);
    $display("done %s", name);
  endtask

  task automatic summarize;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    void'($urandom(80478));
    start(2'h1, 2'h1, 2'h0, 0, 1, 0, 0);
    repeat (20) @(posedge CLK);
    ed_c <= 2'h0;
    soak("sdr rise");
    chk("pins", 3'h5, {FS_HIGH, FS_FROM, DCR});
    chk("trim", 4'h8, TRIM);
    start(2'h0, 2'h0, 2'h0, 0, 0, 0, 0);
    soak("sdr fall");
    start(2'h1, 2'h2, 2'h0, 1, 0, 0, 0);
    soak("ddr");
    start(2'h0, 2'h1, 2'h2, 0, 1, 1, 0);
    soak("interleave pins");
    chk("trim moved", 1, moved);
    // Edge bit kept low: a running edge swap would skip one clock edge
    start(2'h2, 2'h0, 2'h0, 0, 0, 1, 1);
    rd(8'h04, 32'h0000_0480, 0);
    rd(8'h08, 32'h0000_0100, 0);
    fsv = 9'($urandom);
    apb(1, 8'h04, 32'h0000_0440, rv, ev);
    apb(1, 8'h38, 32'h0000_8000, rv, ev);
    apb(1, 8'h08, 32'(fsv), rv, ev);
    soak("extended");
    chk("ext", {1'b1, 1'b0, fsv}, {FS_FROM, DCR, FS_CODE});
    rd(8'h08, 32'(fsv), 0);
    apb(0, 8'h00, 0, rv, ev);
    chk("status", 3'h6, {rv[9], rv[1:0]});
    rd(8'h3C, 32'h0000_0000, 1);
    summarize;
  end
endmodule
`default_nettype wire
